// ### verilog/cgn_clock_gen_unit.sv
`timescale 1ns/1ns
`include "cgn_params.svh"

// Function
// - All control logic runs on the always-on slow control clock; bus clock may stop.
// - Base outputs indexed 0 safe, 1 system, 2 control ... 8 converters.
// - Base outputs take any source; safe and control outputs take ring only.
// - Ring oscillator has no power-down control at all.
// - Each fractional divider takes a PLL output, ring or crystal.
// - PLL input may be the crystal; sources may be shared.
// - Invalid select is dropped, other fields of that write still update.
// - After reset every stage selects the ring oscillator.
// - Selects naming an inactive source are refused and flagged on writeRejected.
// - Presence status shows active sources; activate and deactivate events raised.
// - No rising edge within 32 control cycles means inactive; an edge means active.
// - Sources absent after reset; status valid after 32 control cycles.
// - Dead selected source is not deselected, but its deactivation event fires.
// - Switching is glitch-free; PLL target is held low until locked.
// - Non-PLL switches finish after only the synchronisation hold interval.
// - Old clock stuck high for 32 cycles is forced low.
// - PLL post divider or direct path; lock indication reported.
// - Bypass 0 divides by 2,4,8,16 per select; bypass 1 passes straight.
// - Extra phases enabled by bit; synchronised to main output once locked.
// - Power-down stops PLL, resets dividers, drops lock; clearing resumes.
module cgn_clock_gen_unit #(
  parameter int DETECT_CYCLES = `CGN_DETECT_CYCLES,
  parameter int PLL_SETTLE_CYCLES = `CGN_PLL_SETTLE_CYCLES,
  parameter int HOLD_CYCLES = `CGN_SYNC_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [`CGN_NUM_SRC-1:0] srcClock,
  input wire logic pllLockRaw,
  input wire cgn_pkg::cgn_cfg_write_type cfgWrite,
  input wire cgn_pkg::cgn_pll_ctrl_type cfgPll,
  output logic [`CGN_NUM_STAGE-1:0][`CGN_SEL_W-1:0] stageSel,
  output logic [`CGN_NUM_STAGE-1:0] stageGateOn,
  output logic [`CGN_NUM_STAGE-1:0] stageForceLow,
  output logic [`CGN_NUM_STAGE-1:0] stageBusy,
  output logic [`CGN_NUM_STAGE-1:0] stageSrcDead,
  output logic [`CGN_NUM_SRC-1:0] presence,
  output logic presenceValid,
  output logic [`CGN_NUM_SRC-1:0] srcUp,
  output logic [`CGN_NUM_SRC-1:0] srcDown,
  output logic writeRejected,
  output cgn_pkg::cgn_pll_ctrl_type pllCtrl,
  output logic pllDividerReset,
  output logic pllLock,
  output logic pllPhaseSync,
  output logic [4:0] pllPostDivRatio
);
  localparam int NSRC = `CGN_NUM_SRC;
  localparam int NSTG = `CGN_NUM_STAGE;
  localparam int SW = `CGN_SEL_W;
  localparam int DCNT_W = $clog2(DETECT_CYCLES + 1);

  generate
    if (DETECT_CYCLES < 2 || DETECT_CYCLES > 255) begin : g_bad_detect
      $error("cgn_clock_gen_unit: DETECT_CYCLES out of range");
    end
    if (PLL_SETTLE_CYCLES < HOLD_CYCLES || HOLD_CYCLES < 1) begin : g_bad_hold
      $error("cgn_clock_gen_unit: hold or settle cycles out of range");
    end
  endgenerate

  // Allowed source per stage, before the presence mask
  function automatic logic selAllowed(input logic [`CGN_TGT_W-1:0] tgt,
                                      input logic [SW-1:0] sel);
    logic ok;
    ok = 1'b0;
    if (tgt == `CGN_BASE_SAFE || tgt == `CGN_BASE_PCR) begin
      ok = (sel == `CGN_SRC_RING);
    end else if (tgt < `CGN_STAGE_FDIV0) begin
      ok = (sel <= `CGN_SRC_FDIV_LAST);
    end else if (tgt < `CGN_STAGE_PLL) begin
      ok = (sel <= `CGN_SRC_PLL240);
    end else if (tgt == `CGN_STAGE_PLL) begin
      // Ring kept legal since it is the reset source; never a PLL or divider
      ok = (sel == `CGN_SRC_XTAL) || (sel == `CGN_SRC_RING);
    end
    return ok;
  endfunction : selAllowed

  function automatic logic isPllSrc(input logic [SW-1:0] sel);
    return (sel >= `CGN_SRC_PLL0) && (sel <= `CGN_SRC_PLL240);
  endfunction : isPllSrc

  // Source sampling and activity detection
  logic [NSRC-1:0] srcMeta_ff;
  logic [NSRC-1:0] srcSync_ff;
  logic [NSRC-1:0] srcPrev_ff;
  logic [NSRC-1:0] srcEdge;
  logic [NSRC-1:0] nxt_presence;

  assign srcEdge = srcSync_ff & ~srcPrev_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      srcMeta_ff <= '0;
      srcSync_ff <= '0;
      srcPrev_ff <= '0;
    end else if (clkEn) begin
      srcMeta_ff <= srcClock;
      srcSync_ff <= srcMeta_ff;
      srcPrev_ff <= srcSync_ff;
    end
  end

  genvar s;
  generate
    for (s = 0; s < NSRC; s++) begin : g_detect
      logic [DCNT_W-1:0] idleCnt_ff;
      wire idleExpired = (idleCnt_ff == DCNT_W'(DETECT_CYCLES - 1));

      // Edge marks present, a full idle window marks absent
      assign nxt_presence[s] = srcEdge[s] ? 1'b1 : (idleExpired ? 1'b0 : presence[s]);

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          idleCnt_ff <= '0;
          presence[s] <= 1'b0;
          srcUp[s] <= 1'b0;
          srcDown[s] <= 1'b0;
        end else if (clkEn) begin
          if (srcEdge[s] || idleExpired) begin
            idleCnt_ff <= '0;
          end else begin
            idleCnt_ff <= idleCnt_ff + 1'b1;
          end
          presence[s] <= nxt_presence[s];
          srcUp[s] <= nxt_presence[s] & ~presence[s];
          // Fires even when the dead source is still selected
          srcDown[s] <= ~nxt_presence[s] & presence[s];
        end
      end
    end
  endgenerate

  // Status is only trustworthy after one full detection window
  logic [DCNT_W-1:0] validCnt_ff;
  wire validReached = (validCnt_ff == DCNT_W'(DETECT_CYCLES - 1));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      validCnt_ff <= '0;
      presenceValid <= 1'b0;
    end else if (clkEn) begin
      if (!presenceValid) begin
        validCnt_ff <= validCnt_ff + 1'b1;
      end
      if (validReached) begin
        presenceValid <= 1'b1;
      end
    end
  end

  // Write checking
  wire tgtInRange = (cfgWrite.target <= `CGN_STAGE_PLL);
  wire srcInRange = (cfgWrite.sel <= `CGN_SRC_FDIV_LAST);
  wire srcActive = srcInRange && presence[cfgWrite.sel[SW-1:0]];
  wire selOk = selAllowed(cfgWrite.target, cfgWrite.sel) && srcActive;
  wire selAccept = cfgWrite.write && tgtInRange && selOk;
  wire selReject = cfgWrite.write && tgtInRange && !selOk;
  wire pllFieldWrite = cfgWrite.write && (cfgWrite.target == `CGN_STAGE_PLL);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      writeRejected <= 1'b0;
    end else if (clkEn) begin
      writeRejected <= selReject;
    end
  end

  // PLL control fields and lock handling
  logic lockMeta_ff;
  logic lockSync_ff;
  cgn_pkg::cgn_pll_ctrl_type nxt_pllCtrl;
  logic [4:0] nxt_ratio;

  // Other fields take effect even if the select part was refused
  assign nxt_pllCtrl = pllFieldWrite ? cfgPll : pllCtrl;
  // Post divider 2 << psel, or one when the direct path is used
  assign nxt_ratio = nxt_pllCtrl.bypass ? `CGN_PDIV_DIRECT
                                        : 5'(`CGN_PDIV_BASE << nxt_pllCtrl.psel);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lockMeta_ff <= 1'b0;
      lockSync_ff <= 1'b0;
      pllCtrl.powerDown <= `CGN_PLL_PD_RST;
      pllCtrl.bypass <= `CGN_PLL_BYPASS_RST;
      pllCtrl.psel <= `CGN_PLL_PSEL_RST;
      pllCtrl.extraPhase <= `CGN_PLL_XPH_RST;
      pllDividerReset <= `CGN_PLL_PD_RST;
      pllLock <= 1'b0;
      pllPhaseSync <= 1'b0;
      pllPostDivRatio <= `CGN_PDIV_BASE;
    end else if (clkEn) begin
      lockMeta_ff <= pllLockRaw;
      lockSync_ff <= lockMeta_ff;
      // Only the PLL has a power-down control; the ring oscillator has none
      pllCtrl <= nxt_pllCtrl;
      pllDividerReset <= nxt_pllCtrl.powerDown;
      // Lock held low in power-down, reported again once regained
      pllLock <= lockSync_ff & ~nxt_pllCtrl.powerDown;
      // Extra phases run free until lock, then align to the main output
      pllPhaseSync <= nxt_pllCtrl.extraPhase & lockSync_ff & ~nxt_pllCtrl.powerDown;
      pllPostDivRatio <= nxt_ratio;
    end
  end

  // Switching stages: base outputs, dividers and PLL input
  logic [NSTG-1:0] stageReq;
  logic [NSTG-1:0] stageOldLevel;
  logic [NSTG-1:0] stageCurPll;

  genvar k;
  generate
    for (k = 0; k < NSTG; k++) begin : g_stage
      localparam logic [`CGN_TGT_W-1:0] TGT = `CGN_TGT_W'(k);
      wire [SW-1:0] curSrc = stageSel[k];

      // Base output index equals stage index
      assign stageReq[k] = selAccept && (cfgWrite.target == TGT);
      assign stageOldLevel[k] = (curSrc <= `CGN_SRC_FDIV_LAST) ? srcSync_ff[curSrc] : 1'b0;
      assign stageCurPll[k] = isPllSrc(curSrc);

      cgn_switch_stage #(
        .SEL_W(SW),
        .TIMEOUT_CYCLES(DETECT_CYCLES),
        .SETTLE_CYCLES(PLL_SETTLE_CYCLES),
        .HOLD_CYCLES(HOLD_CYCLES)
      ) u_stage (
        .core_clk(core_clk),
        .reset(reset),
        .clkEn(clkEn),
        .reqValid(stageReq[k]),
        .reqSel(cfgWrite.sel),
        .oldLevel(stageOldLevel[k]),
        .curIsPll(stageCurPll[k]),
        .pllLocked(pllLock),
        .curSel(stageSel[k]),
        .gateOn(stageGateOn[k]),
        .forceLow(stageForceLow[k]),
        .busy(stageBusy[k])
      );

      // Selected source that went quiet stays selected, only flagged
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          stageSrcDead[k] <= 1'b0;
        end else if (clkEn) begin
          stageSrcDead[k] <= presenceValid && (curSrc <= `CGN_SRC_FDIV_LAST)
                             && !presence[curSrc];
        end
      end
    end
  endgenerate

endmodule : cgn_clock_gen_unit

// ### verilog/cgn_params.svh
`ifndef CGN_PARAMS_SVH
`define CGN_PARAMS_SVH

// Source numbering seen by every selector
`define CGN_NUM_SRC 12
`define CGN_SEL_W 4
`define CGN_SRC_RING 4'h0
`define CGN_SRC_XTAL 4'h1
`define CGN_SRC_PLL0 4'h2
`define CGN_SRC_PLL120 4'h3
`define CGN_SRC_PLL240 4'h4
`define CGN_SRC_FDIV0 4'h5
`define CGN_SRC_FDIV_LAST 4'hB

// Stage numbering: base outputs, fractional dividers, PLL input
`define CGN_NUM_BASE 9
`define CGN_NUM_FDIV 7
`define CGN_NUM_STAGE 17
`define CGN_TGT_W 5
`define CGN_BASE_SAFE 5'h00
`define CGN_BASE_SYS 5'h01
`define CGN_BASE_PCR 5'h02
`define CGN_BASE_NET 5'h03
`define CGN_BASE_MOD 5'h04
`define CGN_BASE_UART 5'h05
`define CGN_BASE_SSP 5'h06
`define CGN_BASE_TMR 5'h07
`define CGN_BASE_CONV 5'h08
`define CGN_STAGE_FDIV0 5'h09
`define CGN_STAGE_PLL 5'h10

// Timing
`define CGN_DETECT_CYCLES 32
`define CGN_CLK_PERIOD_NS 40
`define CGN_PLL_SETTLE_NS 100000
`define CGN_PLL_SETTLE_CYCLES ((`CGN_PLL_SETTLE_NS + `CGN_CLK_PERIOD_NS - 1) / `CGN_CLK_PERIOD_NS)
`define CGN_SYNC_HOLD_CYCLES 2

// PLL control reset values and post-divide encoding
`define CGN_PLL_PD_RST 1'b1
`define CGN_PLL_BYPASS_RST 1'b0
`define CGN_PLL_PSEL_RST 2'h0
`define CGN_PLL_XPH_RST 1'b0
`define CGN_PDIV_BASE 5'h02
`define CGN_PDIV_DIRECT 5'h01

`endif

// ### verilog/cgn_pkg.sv
package cgn_pkg;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_WAIT_LOW,
    SW_HOLD
  } cgn_sw_state_type;

  typedef struct packed {
    logic write;
    logic [4:0] target;
    logic [3:0] sel;
  } cgn_cfg_write_type;

  typedef struct packed {
    logic powerDown;
    logic bypass;
    logic [1:0] psel;
    logic extraPhase;
  } cgn_pll_ctrl_type;

endpackage : cgn_pkg

// ### verilog/cgn_switch_stage.sv
`timescale 1ns/1ns
`include "cgn_params.svh"

module cgn_switch_stage #(
  parameter int SEL_W = `CGN_SEL_W,
  parameter int TIMEOUT_CYCLES = `CGN_DETECT_CYCLES,
  parameter int SETTLE_CYCLES = `CGN_PLL_SETTLE_CYCLES,
  parameter int HOLD_CYCLES = `CGN_SYNC_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire logic [SEL_W-1:0] reqSel,
  input wire logic oldLevel,
  input wire logic curIsPll,
  input wire logic pllLocked,
  output logic [SEL_W-1:0] curSel,
  output logic gateOn,
  output logic forceLow,
  output logic busy
);
  localparam int MAXC = (SETTLE_CYCLES > TIMEOUT_CYCLES) ? SETTLE_CYCLES : TIMEOUT_CYCLES;
  localparam int CNT_W = $clog2(MAXC + 1);

  generate
    if (TIMEOUT_CYCLES < 2 || HOLD_CYCLES < 1 || SETTLE_CYCLES < HOLD_CYCLES) begin : g_bad
      $error("cgn_switch_stage: timing parameters out of range");
    end
  endgenerate

  cgn_pkg::cgn_sw_state_type state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [SEL_W-1:0] pendSel_ff, nxt_cur;
  logic nxt_gate, nxt_force;
  wire holdDone = curIsPll ? (cnt_ff >= CNT_W'(SETTLE_CYCLES) && pllLocked)
                           : (cnt_ff >= CNT_W'(HOLD_CYCLES));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cur = curSel;
    nxt_gate = gateOn;
    nxt_force = forceLow;
    case (state_ff)
      cgn_pkg::SW_RUN: begin
        if (pendSel_ff != curSel) begin
          nxt_state = cgn_pkg::SW_WAIT_LOW;
          nxt_cnt = '0;
        end
      end
      cgn_pkg::SW_WAIT_LOW: begin
        // Gate closes while the old clock is low, or at the timeout if it stays high
        if (!oldLevel || cnt_ff == CNT_W'(TIMEOUT_CYCLES - 1)) begin
          nxt_gate = 1'b0;
          nxt_force = oldLevel; // Stuck-high old clock is forced low
          nxt_cur = pendSel_ff;
          nxt_cnt = '0;
          nxt_state = cgn_pkg::SW_HOLD;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      cgn_pkg::SW_HOLD: begin
        // PLL waits for lock, others only the sync interval
        if (holdDone) begin
          nxt_gate = 1'b1;
          nxt_force = 1'b0;
          nxt_state = cgn_pkg::SW_RUN;
        end else if (cnt_ff != CNT_W'(MAXC)) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      default: nxt_state = cgn_pkg::SW_RUN;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= cgn_pkg::SW_RUN;
      cnt_ff <= '0;
      pendSel_ff <= SEL_W'(`CGN_SRC_RING);
      curSel <= SEL_W'(`CGN_SRC_RING);
      gateOn <= 1'b1;
      forceLow <= 1'b0;
      busy <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (reqValid) pendSel_ff <= reqSel;
      curSel <= nxt_cur;
      gateOn <= nxt_gate;
      forceLow <= nxt_force;
      busy <= (nxt_state != cgn_pkg::SW_RUN);
    end
  end

endmodule : cgn_switch_stage

// ### sim/cgn_src_model.sv
`timescale 1ns/1ns
module cgn_src_model (
  input wire logic [11:0] runMask,
  input wire logic stopHigh,
  input wire logic powerDown,
  output wire logic [11:0] srcClock,
  output logic pllLockRaw
);
  for (genvar i = 0; i < 12; i++) begin : g_src
    logic tick = 1'b0;
    logic run;
    // Ring has no stop path at all
    assign run = i == 0 || (i >= 2 && i <= 4 ? pllLockRaw : runMask[i]);
    // Slower than core_clk so the synchroniser never aliases edges
    always #(50 + 7 * i) tick = ~tick;
    // Stopped source parks at one level, possibly high
    assign srcClock[i] = run ? tick : stopHigh;
  end
  initial pllLockRaw = 1'b0;
  // Lock drops with power-down, returns once settled
  always @(powerDown) begin
    pllLockRaw = 1'b0;
    if (!powerDown) begin
      #2000;
      pllLockRaw = !powerDown;
    end
  end
endmodule : cgn_src_model

// ### sim/cgn_clock_gen_unit_chk.sv
`timescale 1ns/1ns
module cgn_clock_gen_unit_chk #(
  parameter int DETECT_CYCLES = 32,
  parameter int PLL_SETTLE_CYCLES = 8,
  parameter int HOLD_CYCLES = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire cgn_pkg::cgn_cfg_write_type cfgWrite,
  input wire logic [16:0][3:0] stageSel,
  input wire logic [16:0] stageGateOn,
  input wire logic [16:0] stageForceLow,
  input wire logic [11:0] presence,
  input wire logic presenceValid,
  input wire logic [11:0] srcUp,
  input wire logic [11:0] srcDown,
  input wire logic writeRejected,
  input wire cgn_pkg::cgn_pll_ctrl_type pllCtrl,
  input wire logic pllDividerReset,
  input wire logic pllLock,
  input wire logic pllPhaseSync,
  input wire logic [4:0] pllPostDivRatio
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [5:0] upCnt_ff;
  logic [4:0] tgt;
  logic [3:0] sel;
  logic badSel;
  assign tgt = cfgWrite.target;
  assign sel = cfgWrite.sel;
  assign badSel = tgt <= 5'h10 && (sel > 4'hB || !presence[sel]
    || ((tgt == 5'h00 || tgt == 5'h02) && sel != 4'h0)
    || (tgt >= 5'h09 && tgt <= 5'h0F && sel > 4'h4) || (tgt == 5'h10 && sel > 4'h1));
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) upCnt_ff <= 6'h00;
    else if (clkEn && upCnt_ff < DETECT_CYCLES) upCnt_ff <= upCnt_ff + 6'h01;
  end
  sequence s_held_low; !stageGateOn[1] [*3]; endsequence
  sequence s_reopen; ##[0:8] stageGateOn[1]; endsequence
  sequence s_pll_low; !stageGateOn[1] [*8]; endsequence
  a_reset_ring: assert property ($past(reset) |-> stageSel == '0 && &stageGateOn)
    else $error("stage not on ring after reset");
  a_ring_only: assert property (stageSel[0] == 4'h0 && stageSel[2] == 4'h0)
    else $error("safe or control stage left ring");
  // A frozen enable holds the last refusal pulse rather than clearing it
  a_reject_map: assert property (writeRejected == ($past(clkEn)
    ? $past(cfgWrite.write && badSel) : $past(writeRejected)))
    else $error("select refusal wrong");
  a_event_edges: assert property ($past(clkEn) |-> srcUp == (presence & ~$past(presence))
    && srcDown == ($past(presence) & ~presence))
    else $error("presence event wrong");
  a_valid_count: assert property (presenceValid == (upCnt_ff == DETECT_CYCLES))
    else $error("presence valid timing wrong");
  a_sel_gated: assert property ($changed(stageSel[1]) |-> !stageGateOn[1])
    else $error("select changed with gate open");
  a_force_closed: assert property ((stageForceLow & stageGateOn) == '0)
    else $error("forced low with gate open");
  a_nonpll_hold: assert property ($fell(stageGateOn[1]) && (stageSel[1] < 4'h2
    || stageSel[1] > 4'h4) |-> s_held_low ##1 s_reopen)
    else $error("non pll switch hold wrong");
  a_pll_hold: assert property ($fell(stageGateOn[1]) && stageSel[1] == 4'h2 |-> s_pll_low)
    else $error("pll switch reopened early");
  a_pd_lock: assert property (pllDividerReset == pllCtrl.powerDown
    && !(pllCtrl.powerDown && pllLock))
    else $error("power down effects wrong");
  a_ratio_map: assert property (pllPostDivRatio == (pllCtrl.bypass ? 5'h01
    : 5'h02 << pllCtrl.psel))
    else $error("post divide ratio wrong");
  a_phase_sync: assert property (pllPhaseSync == (pllCtrl.extraPhase && pllLock))
    else $error("phase sync wrong");
endmodule : cgn_clock_gen_unit_chk

bind cgn_clock_gen_unit cgn_clock_gen_unit_chk #(.DETECT_CYCLES(DETECT_CYCLES),
  .PLL_SETTLE_CYCLES(PLL_SETTLE_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_chk (.core_clk,
  .reset, .clkEn, .cfgWrite, .stageSel, .stageGateOn, .stageForceLow, .presence,
  .presenceValid, .srcUp, .srcDown, .writeRejected, .pllCtrl, .pllDividerReset, .pllLock,
  .pllPhaseSync, .pllPostDivRatio);

// ### sim/cgn_clock_gen_unit_tb_top.sv
`timescale 1ns/1ns
module cgn_clock_gen_unit_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic stopHigh = 1'b0;
  logic [11:0] runMask = 12'h0A3;
  logic [11:0] expPres = 12'h000;
  logic [11:0] srcClock, presence, srcUp, srcDown;
  logic [16:0][3:0] stageSel;
  logic [16:0] stageGateOn, stageForceLow, stageBusy, stageSrcDead;
  logic pllLockRaw, presenceValid, writeRejected, pllDividerReset, pllLock, pllPhaseSync;
  logic [4:0] pllPostDivRatio;
  cgn_pkg::cgn_cfg_write_type cfgWrite = '0;
  cgn_pkg::cgn_pll_ctrl_type cfgPll = 5'h10;
  cgn_pkg::cgn_pll_ctrl_type pllCtrl;
  int miscompares = 0;
  int total_checks = 0;

  always #20 core_clk = ~core_clk;

  cgn_src_model u_cgn_src_model (.runMask, .stopHigh, .powerDown(pllCtrl.powerDown),
    .srcClock, .pllLockRaw);
  cgn_clock_gen_unit #(.PLL_SETTLE_CYCLES(8)) u_cgn_clock_gen_unit (.core_clk, .reset,
    .clkEn, .srcClock, .pllLockRaw, .cfgWrite, .cfgPll, .stageSel, .stageGateOn,
    .stageForceLow, .stageBusy, .stageSrcDead, .presence, .presenceValid, .srcUp, .srcDown,
    .writeRejected, .pllCtrl, .pllDividerReset, .pllLock, .pllPhaseSync, .pllPostDivRatio);

  task automatic check(input logic [67:0] seen, input logic [67:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Model of select legality, kept apart from the design's decode
  function automatic logic refused(input int t, input int s);
    if (t > 16) return 1'b0;
    if (s > 11 || !expPres[s]) return 1'b1;
    if (t == 0 || t == 2) return s != 0;
    if (t >= 9 && t <= 15) return s > 4;
    return t == 16 && s > 1;
  endfunction : refused

  task automatic wr(input int t, input int s, input cgn_pkg::cgn_pll_ctrl_type p);
    logic exp;
    exp = refused(t, s);
    @(posedge core_clk);
    cfgWrite <= {1'b1, t[4:0], s[3:0]};
    cfgPll <= p;
    @(posedge core_clk);
    cfgWrite.write <= 1'b0;
    #1;
    check(writeRejected, exp);
    if (t == 16) begin
      check({pllCtrl, pllPostDivRatio, pllDividerReset},
        {p, p.bypass ? 5'h01 : 5'h02 << p.psel, p.powerDown});
    end
  endtask : wr

  task automatic settle(input int k);
    repeat (2) @(posedge core_clk);
    #1;
    // Busy read off the edge so the flop update is settled
    for (int n = 0; n < 200 && stageBusy[k] !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
  endtask : settle

  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #400000;
    miscompares++;
    complete_run();
  end

  initial begin
    void'($urandom(53));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check(stageSel, 68'h0);
    check(stageGateOn, 17'h1_FFFF);
    check({presence, presenceValid, pllCtrl, pllPostDivRatio}, {13'h0000, 5'h10, 5'h02});
    repeat (40) @(posedge core_clk);
    #1;
    expPres = runMask;
    check({presence, presenceValid}, {expPres, 1'b1});
    // Frozen enable: a quiet source must not be aged out meanwhile
    @(posedge core_clk);
    clkEn <= 1'b0;
    runMask <= 12'h083;
    repeat (45) @(posedge core_clk);
    #1;
    check({presence, presenceValid, stageBusy}, {expPres, 1'b1, 17'h0_0000});
    @(posedge core_clk);
    clkEn <= 1'b1;
    runMask <= 12'h0A3;
    // PLL kept off here so the presence model stays fixed
    for (int i = 0; i < 60; i++) begin
      wr($urandom_range(17), $urandom_range(15), {1'b1, 4'($urandom)});
    end
    @(posedge core_clk);
    runMask <= 12'h083;
    repeat (45) @(posedge core_clk);
    #1;
    expPres = 12'h083;
    check(presence, expPres);
    wr(3, 5, 5'h10);
    @(posedge core_clk);
    runMask <= 12'h0A3;
    repeat (10) @(posedge core_clk);
    expPres = 12'h0A3;
    wr(3, 5, 5'h10);
    wr(1, 7, 5'h10);
    settle(1);
    check(stageSel[1], 4'h7);
    wr(16, 1, 5'h03);
    for (int n = 0; n < 200 && pllLock !== 1'b1; n++) @(posedge core_clk);
    repeat (10) @(posedge core_clk);
    #1;
    expPres = 12'h0BF;
    check({pllLock, pllPhaseSync, presence}, {2'b11, expPres});
    wr(1, 2, 5'h03);
    settle(1);
    check(stageSel[1], 4'h2);
    @(posedge core_clk);
    stopHigh <= 1'b1;
    wr(16, 1, 5'h13);
    repeat (45) @(posedge core_clk);
    #1;
    expPres = 12'h0A3;
    check({pllLock, presence, stageSel[1], stageSrcDead[1]}, {1'b0, expPres, 4'h2, 1'b1});
    wr(1, 0, 5'h13);
    // Old clock stuck high: gate forced shut after the full timeout
    repeat (33) @(posedge core_clk);
    #1;
    check({stageForceLow[1], stageGateOn[1], stageBusy[1], stageSel[1]}, {3'b101, 4'h0});
    settle(1);
    check(stageSel[1], 4'h0);
    complete_run();
  end
endmodule : cgn_clock_gen_unit_tb_top
